// ==== hdl/hms_slave.v ====
// serial management bus slave with pointer-addressed registers of a hardware monitor
// assumes bus pins and strap sense come from pads; converter handshake is on CORE_CLK
`timescale 1ns/1ps
`include "hms_defines.vh"

module hms_slave #(
	parameter [20:0] RST_PULSE_CYCLES = `HMS_RST_PULSE_CYC
) (
	input  wire       CORE_CLK,
	input  wire       NRST,
	input  wire       SCL,
	input  wire       SDA_IN,
	output reg        SDA_OUT,
	output reg        SDA_OE,
	input  wire       MF_STRAP_IN,
	input  wire       MF_STRAP_FLOAT,
	output reg        MF_STRAP_OUT,
	output reg        MF_STRAP_OE,
	input  wire [4:0] CORE_VOLTAGE_CODE,
	output reg        CONV_REQ,
	output reg  [2:0] CONV_CHAN,
	input  wire       CONV_DONE,
	input  wire [7:0] CONV_DATA
);

	// ==========================================
	// input synchronisers
	wire [8:0] sync_w;
	wire       scl_s;
	wire       sda_s;
	wire       mf_in_s;
	wire       mf_float_s;
	wire [4:0] vid_s;

	hms_sync #(
		.WIDTH (9)
	) u_sync (
		.clk  (CORE_CLK),
		.nrst (NRST),
		.din  ({CORE_VOLTAGE_CODE, MF_STRAP_FLOAT, MF_STRAP_IN, SDA_IN, SCL}),
		.dout (sync_w)
	);

	assign scl_s      = sync_w[0];
	assign sda_s      = sync_w[1];
	assign mf_in_s    = sync_w[2];
	assign mf_float_s = sync_w[3];
	assign vid_s      = sync_w[8:4];

	// ==========================================
	// bus edges and conditions
	reg  scl_d_reg;
	reg  sda_d_reg;
	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// ==========================================
	// strap capture
	reg  [1:0] strap_reg;
	reg        strap_done_reg;
	reg  [1:0] strap_next;
	wire [6:0] own_addr = {`HMS_ADDR_HI, strap_reg};

	always @* begin
		if (mf_float_s)
			strap_next = `HMS_STRAP_FLOAT;
		else if (mf_in_s)
			strap_next = `HMS_STRAP_VCC;
		else
			strap_next = `HMS_STRAP_GND;
	end

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			strap_reg      <= `HMS_STRAP_GND;
			strap_done_reg <= 1'b0;
		end else if (start_c && !strap_done_reg) begin
			strap_reg      <= strap_next;
			strap_done_reg <= 1'b1;
		end
	end

	// ==========================================
	// register storage
	reg  [7:0] config_reg;
	reg  [7:0] offset_reg;
	reg  [4:0] vid_reg;
	reg  [7:0] stat_high_reg;
	reg  [7:0] stat_low_reg;
	reg  [7:0] value_mem [0:7];
	reg  [7:0] limit_mem [0:15];
	reg  [7:0] pointer_reg;
	reg  [7:0] rd_data;
	reg        wr_pulse_reg;
	reg  [7:0] wr_data_reg;
	reg        rd_load_reg;
	wire [1:0] mf_mode = config_reg[`HMS_CFG_MODE_HI:`HMS_CFG_MODE_LO];

	always @* begin
		rd_data = 8'h00;
		case (pointer_reg)
			`HMS_REG_CONFIG:    rd_data = config_reg;
			`HMS_REG_OFFSET:    rd_data = offset_reg;
			`HMS_REG_VID_LO:    rd_data = {4'h0, vid_reg[3:0]};
			// bit 4 zero in analog mode
			`HMS_REG_VID_HI:    rd_data = {7'h00, vid_reg[4] & config_reg[`HMS_CFG_CORE_VOLTAGE_CODE_BIT4_DIG]};
			`HMS_REG_STAT_HIGH: rd_data = stat_high_reg;
			`HMS_REG_STAT_LOW:  rd_data = stat_low_reg;
			default: begin
				if (pointer_reg[7:3] == `HMS_REG_VALUE_BASE >> 3)
					rd_data = value_mem[pointer_reg[2:0]];
				else if (pointer_reg[7:4] == `HMS_REG_LIMIT_BASE >> 4)
					rd_data = limit_mem[pointer_reg[3:0]];
			end
		endcase
	end

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST)
			vid_reg <= 5'h00;
		else
			vid_reg <= vid_s;
	end

	integer k;
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			config_reg <= `HMS_CONFIG_RESET;
			offset_reg <= `HMS_OFFSET_RESET;
			for (k = 0; k < 16; k = k + 1)
				limit_mem[k] <= k[0] ? `HMS_LIMIT_LO_RESET : `HMS_LIMIT_HI_RESET;
		end else begin
			// reset trigger bit is a one-shot, never held
			if (config_reg[`HMS_CFG_RST_GO])
				config_reg[`HMS_CFG_RST_GO] <= 1'b0;
			if (wr_pulse_reg) begin
				if (pointer_reg == `HMS_REG_CONFIG)
					config_reg <= wr_data_reg;
				else if (pointer_reg == `HMS_REG_OFFSET)
					offset_reg <= wr_data_reg;
				else if (pointer_reg[7:4] == `HMS_REG_LIMIT_BASE >> 4)
					limit_mem[pointer_reg[3:0]] <= wr_data_reg;
			end
		end
	end

	// ==========================================
	// measurement sequencer
	reg  [1:0] sq_state_reg;
	reg        store_reg;
	reg  [7:0] store_data_reg;
	reg  [2:0] store_chan_reg;
	wire       temp_sel = config_reg[`HMS_CFG_OFS_EXT] ? (CONV_CHAN == `HMS_CHAN_EXT_TEMP)
	                                                   : (CONV_CHAN == `HMS_CHAN_INT_TEMP);
	wire [7:0] adj_data = temp_sel ? CONV_DATA + offset_reg : CONV_DATA;

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			sq_state_reg   <= `HMS_SQ_IDLE;
			CONV_REQ       <= 1'b0;
			CONV_CHAN      <= 3'h0;
			store_reg      <= 1'b0;
			store_data_reg <= 8'h00;
			store_chan_reg <= 3'h0;
		end else begin
			CONV_REQ  <= 1'b0;
			store_reg <= 1'b0;
			case (sq_state_reg)
				`HMS_SQ_IDLE: begin
					if (config_reg[`HMS_CFG_START])
						sq_state_reg <= `HMS_SQ_REQ;
				end
				`HMS_SQ_REQ: begin
					CONV_REQ     <= 1'b1;
					sq_state_reg <= `HMS_SQ_WAIT;
				end
				`HMS_SQ_WAIT: begin
					if (CONV_DONE) begin
						store_reg      <= 1'b1;
						store_data_reg <= adj_data;
						store_chan_reg <= CONV_CHAN;
						CONV_CHAN      <= CONV_CHAN + 3'h1;
						sq_state_reg   <= config_reg[`HMS_CFG_START] ? `HMS_SQ_REQ
						                                             : `HMS_SQ_IDLE;
					end
				end
				default: sq_state_reg <= `HMS_SQ_IDLE;
			endcase
		end
	end

	// ==========================================
	// per-channel value store and limit check
	wire clr_high = rd_load_reg && (pointer_reg == `HMS_REG_STAT_HIGH);
	wire clr_low  = rd_load_reg && (pointer_reg == `HMS_REG_STAT_LOW);

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_chan
			wire hit = store_reg && (store_chan_reg == g);
			wire [7:0] lim_hi = limit_mem[2*g];
			wire [7:0] lim_lo = limit_mem[2*g+1];
			// temperatures compare signed, voltages unsigned
			wire over  = (g >= 6) ? ($signed(store_data_reg) > $signed(lim_hi))
			                      : (store_data_reg > lim_hi);
			wire under = (g >= 6) ? ($signed(store_data_reg) < $signed(lim_lo))
			                      : (store_data_reg < lim_lo);
			always @(posedge CORE_CLK or negedge NRST) begin
				if (!NRST) begin
					value_mem[g]     <= 8'h00;
					stat_high_reg[g] <= 1'b0;
					stat_low_reg[g]  <= 1'b0;
				end else begin
					if (hit)
						value_mem[g] <= store_data_reg;
					if (hit && over)
						stat_high_reg[g] <= 1'b1;
					else if (clr_high)
						stat_high_reg[g] <= 1'b0;
					if (hit && under)
						stat_low_reg[g] <= 1'b1;
					else if (clr_low)
						stat_low_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================
	// shared pin: reset pulse or interrupt
	reg  [20:0] pulse_cnt_reg;
	reg         pulse_act_reg;
	wire        any_stat = |stat_high_reg | |stat_low_reg;

	// 20 ms low pulse or interrupt level
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			pulse_cnt_reg <= 21'h000000;
			pulse_act_reg <= 1'b0;
			MF_STRAP_OUT  <= 1'b0;
			MF_STRAP_OE   <= 1'b0;
		end else begin
			if (pulse_act_reg) begin
				if (pulse_cnt_reg == RST_PULSE_CYCLES - 21'h000001) begin
					pulse_act_reg <= 1'b0;
					pulse_cnt_reg <= 21'h000000;
				end else begin
					pulse_cnt_reg <= pulse_cnt_reg + 21'h000001;
				end
			end else if (config_reg[`HMS_CFG_RST_GO] && mf_mode == `HMS_MODE_RESET) begin
				pulse_act_reg <= 1'b1;
			end
			// never drive before the strap is read, it would corrupt the address
			MF_STRAP_OE <= strap_done_reg &&
			               ((mf_mode == `HMS_MODE_RESET && pulse_act_reg) ||
			                (mf_mode == `HMS_MODE_INT && config_reg[`HMS_CFG_INT_EN] && any_stat));
		end
	end

	// ==========================================
	// bus engine
	reg [2:0] st_reg;
	reg [3:0] bit_cnt_reg;
	reg [7:0] shift_reg;
	reg [7:0] tx_reg;
	reg [1:0] byte_idx_reg;

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			st_reg       <= `HMS_ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			shift_reg    <= 8'h00;
			tx_reg       <= 8'h00;
			byte_idx_reg <= 2'h0;
			pointer_reg  <= 8'h00;
			wr_pulse_reg <= 1'b0;
			wr_data_reg  <= 8'h00;
			rd_load_reg  <= 1'b0;
			SDA_OUT      <= 1'b0;
			SDA_OE       <= 1'b0;
		end else begin
			wr_pulse_reg <= 1'b0;
			rd_load_reg  <= 1'b0;
			if (start_c) begin
				st_reg       <= `HMS_ST_ADDR;
				bit_cnt_reg  <= 4'h0;
				byte_idx_reg <= 2'h0;
				SDA_OE       <= 1'b0;
			end else if (stop_c) begin
				st_reg <= `HMS_ST_IDLE;
				SDA_OE <= 1'b0;
			end else if (scl_rise) begin
				case (st_reg)
					`HMS_ST_ADDR, `HMS_ST_WRITE: begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					`HMS_ST_READ: bit_cnt_reg <= bit_cnt_reg + 4'h1;
					`HMS_ST_ACK_RD: begin
						if (sda_s)
							st_reg <= `HMS_ST_IGNORE;
					end
					default: st_reg <= st_reg;
				endcase
			end else if (scl_fall) begin
				case (st_reg)
					`HMS_ST_ADDR: begin
						if (bit_cnt_reg == 4'h8) begin
							if (shift_reg[7:1] == own_addr) begin
								SDA_OE <= 1'b1;
								st_reg <= `HMS_ST_ACK_ADDR;
							end else begin
								st_reg <= `HMS_ST_IGNORE;
							end
						end
					end
					`HMS_ST_ACK_ADDR: begin
						bit_cnt_reg <= 4'h0;
						if (shift_reg[0]) begin
							tx_reg      <= rd_data;
							rd_load_reg <= 1'b1;
							SDA_OE      <= ~rd_data[7];
							st_reg      <= `HMS_ST_READ;
						end else begin
							SDA_OE <= 1'b0;
							st_reg <= `HMS_ST_WRITE;
						end
					end
					`HMS_ST_WRITE: begin
						if (bit_cnt_reg == 4'h8) begin
							SDA_OE <= 1'b1;
							st_reg <= `HMS_ST_ACK_WR;
							if (byte_idx_reg == 2'h0) begin
								pointer_reg <= shift_reg;
							end else if (byte_idx_reg == 2'h1) begin
								// second byte stored, later ones dropped
								wr_pulse_reg <= 1'b1;
								wr_data_reg  <= shift_reg;
							end
							if (byte_idx_reg != 2'h2)
								byte_idx_reg <= byte_idx_reg + 2'h1;
						end
					end
					`HMS_ST_ACK_WR: begin
						SDA_OE      <= 1'b0;
						bit_cnt_reg <= 4'h0;
						st_reg      <= `HMS_ST_WRITE;
					end
					`HMS_ST_READ: begin
						if (bit_cnt_reg == 4'h8) begin
							SDA_OE <= 1'b0;
							st_reg <= `HMS_ST_ACK_RD;
						end else begin
							tx_reg <= {tx_reg[6:0], 1'b0};
							SDA_OE <= ~tx_reg[6];
						end
					end
					`HMS_ST_ACK_RD: begin
						tx_reg      <= rd_data;
						rd_load_reg <= 1'b1;
						SDA_OE      <= ~rd_data[7];
						bit_cnt_reg <= 4'h0;
						st_reg      <= `HMS_ST_READ;
					end
					default: st_reg <= st_reg;
				endcase
			end
		end
	end

endmodule // hms_slave

// ==== include/hms_defines.vh ====
// constants for the bus slave and register front end of the hardware monitor
// assumes one 100 MHz core clock and a converter that hands back one code per request
// Summary of operation
// - answer address 01011 plus two strap bits
// - strap: ground 00, floating 10, supply 01
// - floating strap gives address 0101110
// - strap sampled once at first start
// - start, then seven address bits and direction
// - ack matching address, else idle until start
// - direction 0 writes, direction 1 reads
// - nine clocks per byte, change while low
// - rising data with clock high ends transfer
// - direction fixed until a new start
// - writes of one or two bytes, read repeats register while acked
// - first written byte loads the pointer
// - second written byte stores to pointed register
// - read returns register at current pointer
// - pointer-only write changes no data register
// - voltage code captured, bit 4 zero in analog
// - shared pin: 20 ms reset or interrupt
// - cycle inputs, store, compare, flag status
// - signed offset added to one temperature
// - bare receive reads from current pointer
`ifndef HMS_DEFINES_VH
`define HMS_DEFINES_VH

// ==========================================
// bus address
`define HMS_ADDR_HI        5'h0b
`define HMS_STRAP_GND      2'h0
`define HMS_STRAP_FLOAT    2'h2
`define HMS_STRAP_VCC      2'h1

// ==========================================
// register offsets
`define HMS_REG_CONFIG     8'h00
`define HMS_REG_OFFSET     8'h01
`define HMS_REG_VID_LO     8'h02
`define HMS_REG_VID_HI     8'h03
`define HMS_REG_STAT_HIGH  8'h04
`define HMS_REG_STAT_LOW   8'h05
`define HMS_REG_VALUE_BASE 8'h10
`define HMS_REG_LIMIT_BASE 8'h20

// ==========================================
// configuration fields and reset values
`define HMS_CFG_START      0
`define HMS_CFG_INT_EN     1
`define HMS_CFG_RST_GO     2
`define HMS_CFG_CORE_VOLTAGE_CODE_BIT4_DIG   3
`define HMS_CFG_OFS_EXT    4
`define HMS_CFG_MODE_LO    5
`define HMS_CFG_MODE_HI    6
`define HMS_MODE_NONE      2'h0
`define HMS_MODE_RESET     2'h1
`define HMS_MODE_INT       2'h2
`define HMS_CONFIG_RESET   8'h00
`define HMS_OFFSET_RESET   8'h00
`define HMS_LIMIT_HI_RESET 8'hff
`define HMS_LIMIT_LO_RESET 8'h00
`define HMS_CHAN_INT_TEMP  3'h6
`define HMS_CHAN_EXT_TEMP  3'h7

// ==========================================
// timing
`define HMS_CLK_KHZ        100000
`define HMS_RST_PULSE_MS   20
`define HMS_RST_PULSE_CYC  (`HMS_RST_PULSE_MS * `HMS_CLK_KHZ)

// ==========================================
// bus states
`define HMS_ST_IDLE        3'h0
`define HMS_ST_ADDR        3'h1
`define HMS_ST_ACK_ADDR    3'h2
`define HMS_ST_WRITE       3'h3
`define HMS_ST_ACK_WR      3'h4
`define HMS_ST_READ        3'h5
`define HMS_ST_ACK_RD      3'h6
`define HMS_ST_IGNORE      3'h7

// ==========================================
// sequencer states
`define HMS_SQ_IDLE        2'h0
`define HMS_SQ_REQ         2'h1
`define HMS_SQ_WAIT        2'h2

`endif

// ==== hdl/hms_sync.v ====
// two-stage synchroniser for a group of levels from outside the core clock
// assumes the levels change slowly against the core clock
`timescale 1ns/1ps

module hms_sync #(
	parameter WIDTH = 9
) (
	input  wire             clk,
	input  wire             nrst,
	input  wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);

	// ==========================================
	// stages
	// first stage feeds only the second
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= {WIDTH{1'b1}};
			sync_reg <= {WIDTH{1'b1}};
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;

endmodule // hms_sync

// ==== bench/hms_slave_asserts.sv ====
// port assertions for the serial bus slave
// assumes one core clock and a 125 ns bus clock from the master
`timescale 1ns/1ps
module hms_chk (
	input wire       CORE_CLK,
	input wire       NRST,
	input wire       SCL,
	input wire       SDA_IN,
	input wire       SDA_OUT,
	input wire       SDA_OE,
	input wire       MF_STRAP_OUT,
	input wire       CONV_REQ,
	input wire [2:0] CONV_CHAN,
	input wire       CONV_DONE
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	// ==========================================
	// helper: last requested channel
	reg [2:0] last_chan_reg;
	reg       seen_reg;
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			last_chan_reg <= 3'h0;
			seen_reg      <= 1'b0;
		end else if (CONV_REQ) begin
			last_chan_reg <= CONV_CHAN;
			seen_reg      <= 1'b1;
		end
	end
	// ==========================================
	// properties
	property p_sda_low;
		SDA_OUT == 1'b0;
	endproperty
	a_sda_low: assert property (p_sda_low) else $error("data drive not low");
	property p_oe_scl_high;
		(SCL [*6]) |-> $stable(SDA_OE);
	endproperty
	a_oe_scl_high: assert property (p_oe_scl_high) else $error("data moved, clock high");
	property p_ack_hold;
		$rose(SDA_OE) |-> SDA_OE [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("pull-down too short");
	property p_stop_idle;
		(SCL && $rose(SDA_IN)) |=> !SDA_OE [*8];
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("driving after stop");
	property p_pin_low;
		MF_STRAP_OUT == 1'b0;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin drive not low");
	property p_req_space;
		CONV_REQ |=> !CONV_REQ [*4];
	endproperty
	a_req_space: assert property (p_req_space) else $error("request before answer");
	property p_chan_hold;
		CONV_REQ |=> $stable(CONV_CHAN) [*3];
	endproperty
	a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
	property p_chan_next;
		(CONV_REQ && seen_reg) |-> CONV_CHAN == last_chan_reg + 3'h1;
	endproperty
	a_chan_next: assert property (p_chan_next) else $error("channel out of order");
	c_ack: cover property ($rose(SDA_OE));
	c_done: cover property (CONV_DONE);
	c_stop: cover property (SCL && $rose(SDA_IN));
endmodule // hms_chk

bind hms_slave hms_chk u_chk (
	.CORE_CLK(CORE_CLK), .NRST(NRST), .SCL(SCL), .SDA_IN(SDA_IN),
	.SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .MF_STRAP_OUT(MF_STRAP_OUT),
	.CONV_REQ(CONV_REQ), .CONV_CHAN(CONV_CHAN), .CONV_DONE(CONV_DONE));

// ==== bench/hms_master_model.sv ====
// bus master model: clock and data, 125 ns bit time
// assumes a pull-up, so released data reads high
`timescale 1ns/1ps
module hms_master_model (
	input  wire sda_wire,
	output reg  scl,
	output reg  sda_drv
);
	localparam real Q = 31.25;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task start;
		begin
			sda_drv = 1'b0;
			#Q;
			scl = 1'b0;
			#Q;
		end
	endtask
	// data low in clock low, rises with clock high
	task stop;
		begin
			sda_drv = 1'b0;
			#Q;
			scl = 1'b1;
			#Q;
			sda_drv = 1'b1;
			#(2 * Q);
		end
	endtask
	// nine pulses, msb first, data moved with clock low
	task xfer(input [8:0] tx, output [8:0] rx);
		integer i;
		begin
			for (i = 8; i >= 0; i = i - 1) begin
				sda_drv = tx[i];
				#Q;
				scl = 1'b1;
				#Q;
				rx[i] = sda_wire;
				#Q;
				scl = 1'b0;
				#Q;
			end
		end
	endtask
endmodule // hms_master_model

// ==== bench/tb_top.sv ====
// self-checking bench for the bus slave
// assumes the master model owns the bus; converter answered here
`timescale 1ns/1ps
module tb_top;
	reg        CORE_CLK;
	reg        NRST;
	reg        strap_float;
	reg        strap_lvl;
	reg  [4:0] vcode;
	reg        CONV_DONE;
	reg  [7:0] CONV_DATA;
	wire       scl;
	wire       sda_drv;
	wire       sda_oe;
	wire       strap_oe;
	wire       conv_req;
	wire [2:0] conv_chan;
	wire       sda_wire = sda_drv & ~sda_oe;
	integer    error_cnt = 0;
	integer    samples_checked = 0;
	integer    cyc = 0;
	integer    cwait = 0;
	integer    i, k, ptr;
	reg  [7:0] mdl [0:255];
	reg [31:0] rng = 32'd60;
	reg  [6:0] sa;
	reg  [7:0] ofs;
	reg  [8:0] rx;

	hms_master_model u_mst (.sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
	// short reset pulse keeps the run brief
	hms_slave #(.RST_PULSE_CYCLES(21'd50)) u_dut (
		.CORE_CLK(CORE_CLK), .NRST(NRST), .SCL(scl), .SDA_IN(sda_wire),
		.SDA_OUT(), .SDA_OE(sda_oe), .MF_STRAP_IN(strap_lvl & ~strap_oe),
		.MF_STRAP_FLOAT(strap_float), .MF_STRAP_OUT(), .MF_STRAP_OE(strap_oe),
		.CORE_VOLTAGE_CODE(vcode), .CONV_REQ(conv_req), .CONV_CHAN(conv_chan),
		.CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA));

	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	// ==========================================
	// converter: answers three cycles after a request
	always @(negedge CORE_CLK) begin
		CONV_DONE <= 1'b0;
		if (conv_req === 1'b1) begin
			cwait = 3;
			CONV_DATA <= 8'h40 + {5'h0, conv_chan};
		end else if (cwait > 0) begin
			cwait = cwait - 1;
			if (cwait == 0)
				CONV_DONE <= 1'b1;
		end
	end
	always @(posedge CORE_CLK) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			error_cnt = error_cnt + 1;
			close_out;
		end
	end
	// ==========================================
	// shared tasks
	task close_out;
		begin
			$display("checks %0d mismatches %0d", samples_checked, error_cnt);
			if (error_cnt == 0 && samples_checked > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task check(input [7:0] seen, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	function [31:0] xs(input [31:0] x);
		reg [31:0] y;
		begin
			y = x ^ (x << 13);
			y = y ^ (y >> 17);
			xs = y ^ (y << 5);
		end
	endfunction
	task wr(input [7:0] p, input [7:0] d, input two);
		begin
			u_mst.start;
			u_mst.xfer({sa, 1'b0, 1'b1}, rx);
			check({7'h0, rx[0]}, 8'h00);
			u_mst.xfer({p, 1'b1}, rx);
			check({7'h0, rx[0]}, 8'h00);
			ptr = p;
			if (two) begin
				u_mst.xfer({d, 1'b1}, rx);
				check({7'h0, rx[0]}, 8'h00);
				mdl[p] = d;
			end
			u_mst.stop;
		end
	endtask
	task rd;
		begin
			u_mst.start;
			u_mst.xfer({sa, 1'b1, 1'b1}, rx);
			check({7'h0, rx[0]}, 8'h00);
			u_mst.xfer(9'h1ff, rx);
			u_mst.stop;
			check(rx[8:1], mdl[ptr]);
		end
	endtask
	// ==========================================
	// main sequence: one pass per strap level
	initial begin
		NRST = 1'b0;
		strap_float = 1'b1;
		strap_lvl = 1'b1;
		vcode = 5'h00;
		CONV_DONE = 1'b0;
		CONV_DATA = 8'h00;
		for (k = 0; k < 3; k = k + 1) begin
			@(negedge CORE_CLK);
			NRST = 1'b0;
			rng = xs(rng);
			vcode = rng[4:0] | 5'h10;
			ofs = rng[15:8];
			strap_float = (k == 0);
			strap_lvl = (k == 1);
			sa = {5'h0b, k == 0, k == 1};
			for (i = 0; i < 256; i = i + 1)
				mdl[i] = 8'h00;
			for (i = 0; i < 8; i = i + 1)
				mdl[8'h20 + 2 * i] = 8'hff;
			mdl[2] = {4'h0, vcode[3:0]};
			repeat (20) @(negedge CORE_CLK);
			NRST = 1'b1;
			repeat (5) @(negedge CORE_CLK);
			u_mst.start;
			u_mst.xfer({7'h2f, 1'b0, 1'b1}, rx);
			u_mst.stop;
			check({7'h0, rx[0]}, 8'h01);
			strap_float = 1'b0;
			strap_lvl = ~strap_lvl;
			wr(8'h01, ofs, 1'b1);
			wr(8'h21, 8'h5a, 1'b0);
			rd;
			rd;
			wr(8'h20, 8'h00, 1'b0);
			rd;
			wr(8'h01, 8'h00, 1'b0);
			rd;
			wr(8'h02, 8'h00, 1'b0);
			rd;
			wr(8'h03, 8'h00, 1'b0);
			rd;
			wr(8'h00, 8'h09, 1'b1);
			mdl[3] = {7'h0, vcode[4]};
			for (i = 0; i < 8; i = i + 1)
				mdl[8'h10 + i] = 8'h40 + i;
			mdl[8'h16] = 8'h46 + ofs;
			repeat (300) @(negedge CORE_CLK);
			rd;
			wr(8'h03, 8'h00, 1'b0);
			rd;
			wr(8'h16, 8'h00, 1'b0);
			rd;
			wr(8'h17, 8'h00, 1'b0);
			rd;
			// high limits of ff are -1 on the signed temperature channels
			mdl[4] = {1'b1, ~mdl[8'h16][7], 6'h00};
			mdl[5] = {1'b0, mdl[8'h16][7], 6'h00};
			wr(8'h04, 8'h00, 1'b0);
			rd;
			wr(8'h05, 8'h00, 1'b0);
			rd;
			// interrupt mode: sticky status pulls the shared pin
			wr(8'h00, 8'h4b, 1'b1);
			repeat (60) @(negedge CORE_CLK);
			check({7'h0, strap_oe}, 8'h01);
			// reset mode with one-shot trigger
			wr(8'h00, 8'h2d, 1'b1);
			@(negedge CORE_CLK);
			check({7'h0, strap_oe}, 8'h01);
			repeat (60) @(negedge CORE_CLK);
			check({7'h0, strap_oe}, 8'h00);
			mdl[0] = 8'h29;
			rd;
			$display("pass %0d done", k);
		end
		close_out;
	end
endmodule // tb_top
